// File: rtl/fpu_frame_pkg.sv
// Constants, encodings and helpers shared by the exception state frame block
`default_nettype none
package fpu_frame_pkg;

  // Exception cases presented by the pipeline when a frame is built
  typedef enum logic [3:0] {
    CASE_SNAN_OC3,
    CASE_OPERAND_ERROR_OC02,
    CASE_OPERAND_ERROR_OC3,
    CASE_OVERFLOW_EXCEPTION_MOVREG,
    CASE_OVERFLOW_EXCEPTION_ARITH,
    CASE_OVERFLOW_EXCEPTION_MOVMEM,
    CASE_UNDERFLOW_EXCEPTION_MOVREG,
    CASE_UNDERFLOW_EXCEPTION_ARITH,
    CASE_UNDERFLOW_EXCEPTION_MOVMEM,
    CASE_DIV_ZERO
  } exc_case_t;

  // Operand type tags
  localparam logic [2:0] TAG_NORM = 3'h0;
  localparam logic [2:0] TAG_ZERO = 3'h1;
  localparam logic [2:0] TAG_INF = 3'h2;
  localparam logic [2:0] TAG_NAN = 3'h3;
  localparam logic [2:0] TAG_EXT_DENORM = 3'h4;
  localparam logic [2:0] TAG_SD_DENORM = 3'h5;

  // Opclass field of the stage one command word
  localparam int OPCLASS_MSB = 15;
  localparam int OPCLASS_LSB = 13;
  localparam logic [2:0] OPCLASS_REG = 3'h0;
  localparam logic [2:0] OPCLASS_MEM = 3'h2;
  localparam logic [2:0] OPCLASS_OUT = 3'h3;

  // Extended format details
  localparam logic [14:0] EXP_MAX = 15'h7FFF;
  localparam int SNAN_BIT = 62;
  localparam int WB_EXP_MSB = 15;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_SRC_LO = 8'h14;
  localparam logic [7:0] OFS_SRC_HI = 8'h18;
  localparam logic [7:0] OFS_SRC_SE = 8'h1C;
  localparam logic [7:0] OFS_DST_LO = 8'h20;
  localparam logic [7:0] OFS_DST_HI = 8'h24;
  localparam logic [7:0] OFS_DST_SE = 8'h28;
  localparam logic [7:0] OFS_WB_LO = 8'h2C;
  localparam logic [7:0] OFS_WB_MID = 8'h30;
  localparam logic [7:0] OFS_WB_TOP = 8'h34;
  localparam logic [7:0] OFS_WB_SE = 8'h38;

  // Status and mask bit positions
  localparam int STS_BUILT = 0;
  localparam int STS_MISMATCH = 1;
  localparam int STS_OVERRUN = 2;
  localparam int STS_W = 3;

  // Flags register bit positions; sign and sticky sit at bit 31 of their own words
  localparam int FLG_E1 = 0;
  localparam int FLG_E3 = 1;
  localparam int FLG_POST = 2;
  localparam int FLG_SOURCE_TYPE_TAG = 4;
  localparam int FLG_DESTINATION_TYPE_TAG = 8;
  localparam int FLG_CASE = 16;
  localparam int FLG_OPCLASS = 21;
  localparam int SIGN_POS = 31;
  localparam int STICKY_POS = 31;

  // Reset values
  localparam logic RST_CTRL_EN = 1'b1;
  localparam logic [2:0] RST_MASK = 3'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_WB_SE);
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

endpackage
`default_nettype wire

// File: rtl/fpu_operand_tagger.sv
// Operand type tag encoder for one extended-precision operand
`timescale 1ns/1ps
`default_nettype none
module fpu_operand_tagger
  import fpu_frame_pkg::*;
(
  // Operand
  input wire logic [14:0] i_exp,
  input wire logic [63:0] i_mant,
  input wire logic i_sd_denorm_src,
  // Tag
  output logic [2:0] o_tag
);

  always_comb
  begin
    if (i_exp == EXP_MAX)
      o_tag = (i_mant[62:0] == 63'h0) ? TAG_INF : TAG_NAN;
    else if (i_exp == 15'h0 && i_mant == 64'h0)
      o_tag = TAG_ZERO;
    else if (i_sd_denorm_src)
      o_tag = TAG_SD_DENORM;
    else if (i_exp == 15'h0 || !i_mant[63])
      o_tag = TAG_EXT_DENORM;
    else
      o_tag = TAG_NORM;
  end

endmodule // fpu_operand_tagger
`default_nettype wire

// File: rtl/fpu_frame_axi_slave.sv
// AXI4-Lite slave front end: up to two writes (one awaiting its response) and one read outstanding
`timescale 1ns/1ps
`default_nettype none
module fpu_frame_axi_slave
  import fpu_frame_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // AXI4-Lite
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Register side
  output logic o_wr_en,
  output logic [7:0] o_wr_addr,
  output logic [31:0] o_wr_data,
  output logic [3:0] o_wr_strb,
  output logic [7:0] o_rd_addr,
  input wire logic [31:0] i_rd_data
);

  typedef struct packed {
    logic aw_full;
    logic [7:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic arready;
    logic awready;
    logic wready;
    logic rst_done;
  } axi_state_t;

  axi_state_t s_r, s_nxt;
  logic issue;

  assign issue = s_r.aw_full && s_r.w_full && !s_r.bvalid;
  assign o_wr_en = issue;
  assign o_wr_addr = s_r.awaddr;
  assign o_wr_data = s_r.wdata;
  assign o_wr_strb = s_r.wstrb;
  assign o_rd_addr = i_araddr;

  always_comb
  begin
    s_nxt = s_r;
    if (s_r.awready && i_awvalid)
    begin
      s_nxt.aw_full = 1'b1;
      s_nxt.awaddr = i_awaddr;
    end
    if (s_r.wready && i_wvalid)
    begin
      s_nxt.w_full = 1'b1;
      s_nxt.wdata = i_wdata;
      s_nxt.wstrb = i_wstrb;
    end
    if (s_r.bvalid && i_bready)
      s_nxt.bvalid = 1'b0;
    // Unmapped writes are dropped and answered with an error
    if (issue)
    begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = is_mapped(s_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_r.rvalid && i_rready)
      s_nxt.rvalid = 1'b0;
    // Reads have no side effects, so data is sampled at address accept
    if (s_r.arready && i_arvalid)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = is_mapped(i_araddr) ? i_rd_data : 32'h0;
      s_nxt.rresp = is_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    s_nxt.arready = !s_nxt.rvalid;
    // Write readies come up one cycle after the read side, once reset has settled
    s_nxt.awready = !s_nxt.aw_full && s_r.rst_done;
    s_nxt.wready = !s_nxt.w_full && s_r.rst_done;
    s_nxt.rst_done = 1'b1;
    if (!i_rst_n)
      s_nxt = '0;
  end

  always_ff @(posedge i_core_clk)
    s_r <= s_nxt;

  assign o_awready = s_r.awready;
  assign o_wready = s_r.wready;
  assign o_bvalid = s_r.bvalid;
  assign o_bresp = s_r.bresp;
  assign o_arready = s_r.arready;
  assign o_rvalid = s_r.rvalid;
  assign o_rresp = s_r.rresp;
  assign o_rdata = s_r.rdata;

endmodule // fpu_frame_axi_slave
`default_nettype wire

// File: rtl/fpu_exception_state_frame.sv
// Floating-point exception state frame builder with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module fpu_exception_state_frame
  import fpu_frame_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Exception event from the pipeline
  input wire logic i_exc_valid,
  input wire fpu_frame_pkg::exc_case_t i_exc_case,
  input wire logic [15:0] i_stage1_command_word,
  input wire logic [15:0] i_stage3_encoded_command,
  // Operands in extended precision
  input wire logic i_src_sign,
  input wire logic [14:0] i_src_exp,
  input wire logic [63:0] i_src_mant,
  input wire logic i_src_sd_denorm,
  input wire logic i_dst_sign,
  input wire logic [14:0] i_dst_exp,
  input wire logic [63:0] i_dst_mant,
  input wire logic i_dst_sd_denorm,
  input wire logic i_dst_present,
  // Intermediate result before rounding
  input wire logic i_int_sign,
  input wire logic [14:0] i_int_exp,
  input wire logic [66:0] i_int_mant,
  input wire logic i_int_sticky,
  // Intermediate result rounded to precision, and rounded integer
  input wire logic i_rnd_sign,
  input wire logic [14:0] i_rnd_exp,
  input wire logic [63:0] i_rnd_mant,
  input wire logic [63:0] i_round_int,
  // AXI4-Lite
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Interrupt
  output logic o_irq
);

  typedef struct packed {
    logic ctrl_en;
    logic [STS_W-1:0] status;
    logic [STS_W-1:0] mask;
    logic [15:0] stage1_command_word;
    logic [15:0] stage3_encoded_command;
    logic src_sign;
    logic [14:0] src_exp;
    logic [63:0] src_mant;
    logic dst_sign;
    logic [14:0] dst_exp;
    logic [63:0] dst_mant;
    logic writeback_sign;
    logic [15:0] writeback_exponent;
    logic [66:0] writeback_mantissa;
    logic sticky_bit;
    logic [2:0] source_type_tag;
    logic [2:0] destination_type_tag;
    logic stage_one_flag;
    logic stage_three_flag;
    logic post_flag;
    exc_case_t last_case;
    logic irq;
  } frame_state_t;

  frame_state_t s_r, s_nxt;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic [2:0] src_tag;
  logic [2:0] dst_tag;
  logic [2:0] opclass;
  logic [STS_W-1:0] sts_set;
  logic [31:0] wr_word;
  logic [31:0] wr_mask;
  logic [31:0] mask_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Submodules

  fpu_operand_tagger u_src_tagger (
    .i_exp(i_src_exp),
    .i_mant(i_src_mant),
    .i_sd_denorm_src(i_src_sd_denorm),
    .o_tag(src_tag)
  );

  fpu_operand_tagger u_dst_tagger (
    .i_exp(i_dst_exp),
    .i_mant(i_dst_mant),
    .i_sd_denorm_src(i_dst_sd_denorm),
    .o_tag(dst_tag)
  );

  fpu_frame_axi_slave u_axi (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_awaddr(i_s_axi_awaddr),
    .i_awvalid(i_s_axi_awvalid),
    .o_awready(o_s_axi_awready),
    .i_wdata(i_s_axi_wdata),
    .i_wstrb(i_s_axi_wstrb),
    .i_wvalid(i_s_axi_wvalid),
    .o_wready(o_s_axi_wready),
    .o_bresp(o_s_axi_bresp),
    .o_bvalid(o_s_axi_bvalid),
    .i_bready(i_s_axi_bready),
    .i_araddr(i_s_axi_araddr),
    .i_arvalid(i_s_axi_arvalid),
    .o_arready(o_s_axi_arready),
    .o_rdata(o_s_axi_rdata),
    .o_rresp(o_s_axi_rresp),
    .o_rvalid(o_s_axi_rvalid),
    .i_rready(i_s_axi_rready),
    .o_wr_en(wr_en),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Frame capture and registers

  assign opclass = i_stage1_command_word[OPCLASS_MSB:OPCLASS_LSB];
  assign wr_mask = apply_strb(32'h0, 32'hFFFFFFFF, wr_strb);
  assign wr_word = wr_data & wr_mask;
  assign mask_word = apply_strb({29'h0, s_r.mask}, wr_data, wr_strb);

  always_comb
  begin
    s_nxt = s_r;
    sts_set = '0;
    // Capture is suppressed while disabled; the pipeline is not stalled
    if (i_exc_valid && s_r.ctrl_en)
    begin
      sts_set[STS_BUILT] = 1'b1;
      sts_set[STS_OVERRUN] = s_r.status[STS_BUILT];
      s_nxt.last_case = i_exc_case;
      s_nxt.stage_one_flag = 1'b1;
      s_nxt.stage_three_flag = 1'b0;
      s_nxt.post_flag = 1'b0;
      // Fields a case does not name are left as they were
      unique case (i_exc_case)
        CASE_SNAN_OC3:
        begin
          s_nxt.stage1_command_word = i_stage1_command_word;
          s_nxt.src_sign = i_src_sign;
          s_nxt.src_exp = i_src_exp;
          s_nxt.src_mant = i_src_mant;
          s_nxt.src_mant[SNAN_BIT] = 1'b1;
          s_nxt.source_type_tag = TAG_NAN;
          s_nxt.post_flag = 1'b1;
          sts_set[STS_MISMATCH] = (opclass != OPCLASS_OUT);
        end
        CASE_OPERAND_ERROR_OC02, CASE_DIV_ZERO:
        begin
          s_nxt.stage1_command_word = i_stage1_command_word;
          s_nxt.src_sign = i_src_sign;
          s_nxt.src_exp = i_src_exp;
          s_nxt.src_mant = i_src_mant;
          s_nxt.source_type_tag = src_tag;
          if (i_dst_present || i_exc_case == CASE_DIV_ZERO)
          begin
            s_nxt.dst_sign = i_dst_sign;
            s_nxt.dst_exp = i_dst_exp;
            s_nxt.dst_mant = i_dst_mant;
          end
          if (i_exc_case == CASE_OPERAND_ERROR_OC02 && i_dst_present)
            s_nxt.destination_type_tag = dst_tag;
          sts_set[STS_MISMATCH] = (opclass != OPCLASS_REG) && (opclass != OPCLASS_MEM);
        end
        CASE_OPERAND_ERROR_OC3:
        begin
          s_nxt.stage1_command_word = i_stage1_command_word;
          s_nxt.src_sign = i_src_sign;
          s_nxt.src_exp = i_src_exp;
          s_nxt.src_mant = i_src_mant;
          s_nxt.source_type_tag = src_tag;
          s_nxt.writeback_mantissa = {3'h0, i_round_int};
          s_nxt.post_flag = 1'b1;
          sts_set[STS_MISMATCH] = (opclass != OPCLASS_OUT);
        end
        CASE_OVERFLOW_EXCEPTION_MOVREG, CASE_OVERFLOW_EXCEPTION_MOVMEM:
        begin
          s_nxt.stage1_command_word = i_stage1_command_word;
          s_nxt.dst_sign = i_rnd_sign;
          s_nxt.dst_exp = i_rnd_exp;
          s_nxt.dst_mant = i_rnd_mant;
          s_nxt.source_type_tag = TAG_NORM;
          s_nxt.post_flag = (i_exc_case == CASE_OVERFLOW_EXCEPTION_MOVMEM);
          sts_set[STS_MISMATCH] = s_nxt.post_flag != (opclass == OPCLASS_OUT);
        end
        CASE_UNDERFLOW_EXCEPTION_MOVREG, CASE_UNDERFLOW_EXCEPTION_MOVMEM:
        begin
          s_nxt.stage1_command_word = i_stage1_command_word;
          s_nxt.dst_sign = i_int_sign;
          s_nxt.dst_exp = i_int_exp;
          s_nxt.dst_mant = i_int_mant[65:2];
          s_nxt.source_type_tag = TAG_NORM;
          s_nxt.post_flag = (i_exc_case == CASE_UNDERFLOW_EXCEPTION_MOVMEM);
          sts_set[STS_MISMATCH] = s_nxt.post_flag != (opclass == OPCLASS_OUT);
        end
        CASE_OVERFLOW_EXCEPTION_ARITH:
        begin
          s_nxt.stage_one_flag = 1'b0;
          s_nxt.stage_three_flag = 1'b1;
          s_nxt.stage3_encoded_command = i_stage3_encoded_command;
          s_nxt.writeback_sign = i_rnd_sign;
          s_nxt.writeback_exponent = {1'b0, i_rnd_exp};
          s_nxt.writeback_mantissa = {1'b0, i_rnd_mant, 2'h0};
        end
        CASE_UNDERFLOW_EXCEPTION_ARITH:
        begin
          s_nxt.stage_one_flag = 1'b0;
          s_nxt.stage_three_flag = 1'b1;
          s_nxt.stage3_encoded_command = i_stage3_encoded_command;
          s_nxt.writeback_sign = i_int_sign;
          s_nxt.writeback_exponent = {1'b1, i_int_exp};
          s_nxt.writeback_mantissa = i_int_mant;
          s_nxt.sticky_bit = i_int_sticky;
        end
        default:
        begin
          sts_set[STS_MISMATCH] = 1'b1;
        end
      endcase
    end
    // Register writes; a new event wins over a clearing write
    if (wr_en)
    begin
      unique case (wr_addr)
        OFS_CTRL: s_nxt.ctrl_en = wr_strb[0] ? wr_data[0] : s_r.ctrl_en;
        OFS_STATUS: s_nxt.status = s_r.status & ~wr_word[STS_W-1:0];
        OFS_MASK: s_nxt.mask = mask_word[STS_W-1:0];
        default: ;
      endcase
    end
    s_nxt.status = s_nxt.status | sts_set;
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
    if (!i_rst_n)
    begin
      s_nxt = '0;
      s_nxt.ctrl_en = RST_CTRL_EN;
      s_nxt.mask = RST_MASK;
      s_nxt.last_case = CASE_SNAN_OC3;
    end
  end

  always_ff @(posedge i_core_clk)
    s_r <= s_nxt;

  assign o_irq = s_r.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Read decode

  always_comb
  begin
    rd_data = 32'h0;
    unique case (rd_addr)
      OFS_CTRL: rd_data[0] = s_r.ctrl_en;
      OFS_STATUS: rd_data[STS_W-1:0] = s_r.status;
      OFS_MASK: rd_data[STS_W-1:0] = s_r.mask;
      OFS_FLAGS:
      begin
        rd_data[FLG_E1] = s_r.stage_one_flag;
        rd_data[FLG_E3] = s_r.stage_three_flag;
        rd_data[FLG_POST] = s_r.post_flag;
        rd_data[FLG_SOURCE_TYPE_TAG +: 3] = s_r.source_type_tag;
        rd_data[FLG_DESTINATION_TYPE_TAG +: 3] = s_r.destination_type_tag;
        rd_data[FLG_CASE +: 4] = s_r.last_case;
        rd_data[FLG_OPCLASS +: 3] = s_r.stage1_command_word[OPCLASS_MSB:OPCLASS_LSB];
      end
      OFS_CMD: rd_data = {s_r.stage3_encoded_command, s_r.stage1_command_word};
      OFS_SRC_LO: rd_data = s_r.src_mant[31:0];
      OFS_SRC_HI: rd_data = s_r.src_mant[63:32];
      OFS_SRC_SE: rd_data = {s_r.src_sign, 16'h0, s_r.src_exp};
      OFS_DST_LO: rd_data = s_r.dst_mant[31:0];
      OFS_DST_HI: rd_data = s_r.dst_mant[63:32];
      OFS_DST_SE: rd_data = {s_r.dst_sign, 16'h0, s_r.dst_exp};
      OFS_WB_LO: rd_data = s_r.writeback_mantissa[31:0];
      OFS_WB_MID: rd_data = s_r.writeback_mantissa[63:32];
      OFS_WB_TOP: rd_data = {s_r.sticky_bit, 28'h0, s_r.writeback_mantissa[66:64]};
      OFS_WB_SE: rd_data = {s_r.writeback_sign, 15'h0, s_r.writeback_exponent};
      default: rd_data = 32'h0;
    endcase
  end

endmodule // fpu_exception_state_frame
`default_nettype wire

// File: tb/fpu_frame_props.sv
// Bus and interrupt properties of the exception frame block
`timescale 1ns/1ps
`default_nettype none
module fpu_frame_props
(
  // Clock, reset, event
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_exc_valid,
  // Register bus
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Interrupt
  input wire logic o_irq
);
  logic aw_t, w_t, ar_t, bad_w, bad_r;
  assign aw_t = i_s_axi_awvalid && o_s_axi_awready;
  assign w_t = i_s_axi_wvalid && o_s_axi_wready;
  assign ar_t = i_s_axi_arvalid && o_s_axi_arready;
  // Misaligned or past the last word is refused
  assign bad_w = (i_s_axi_awaddr[1:0] != 2'h0) || (i_s_axi_awaddr > 8'h38);
  assign bad_r = (i_s_axi_araddr[1:0] != 2'h0) || (i_s_axi_araddr > 8'h38);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////
  property p_b_hold;
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_w_ok;
    aw_t && w_t && !bad_w |=> !o_s_axi_bvalid ##1 (o_s_axi_bvalid && o_s_axi_bresp == 2'h0);
  endproperty
  a_w_ok: assert property (p_w_ok) else $error("write response late or wrong");
  property p_w_bad;
    aw_t && w_t && bad_w |=> ##1 (o_s_axi_bvalid && o_s_axi_bresp == 2'h2);
  endproperty
  a_w_bad: assert property (p_w_bad) else $error("unmapped write not refused");
  property p_r_bad;
    ar_t && bad_r |=> o_s_axi_rvalid && o_s_axi_rresp == 2'h2 && o_s_axi_rdata == 32'h0;
  endproperty
  a_r_bad: assert property (p_r_bad) else $error("unmapped read not refused");
  property p_ar_block;
    o_s_axi_rvalid |-> !o_s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address taken during answer");
  property p_aw_block;
    aw_t |=> !o_s_axi_awready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("second write address taken");
  property p_irq_rst;
    $rose(i_rst_n) |-> !o_irq;
  endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("interrupt high out of reset");
  c_wr: cover property (aw_t && w_t);
  c_rd_bad: cover property (ar_t && bad_r);
  c_irq: cover property ($rose(o_irq));
  c_exc: cover property (i_exc_valid);
endmodule // fpu_frame_props
bind fpu_exception_state_frame fpu_frame_props u_props (.*);
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the exception state frame block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fpu_frame_pkg::*;
  logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_exc_valid = 1'b0;
  exc_case_t i_exc_case = CASE_SNAN_OC3;
  logic [15:0] i_stage1_command_word = '0, i_stage3_encoded_command = '0;
  logic i_src_sign = '0, i_src_sd_denorm = '0, i_dst_sign = '0, i_dst_sd_denorm = '0, i_dst_present = '0;
  logic i_int_sign = '0, i_int_sticky = '0, i_rnd_sign = '0;
  logic [14:0] i_src_exp = '0, i_dst_exp = '0, i_int_exp = '0, i_rnd_exp = '0;
  logic [63:0] i_src_mant = '0, i_dst_mant = '0, i_rnd_mant = '0, i_round_int = '0;
  logic [66:0] i_int_mant = '0;
  logic [7:0] i_s_axi_awaddr = '0, i_s_axi_araddr = '0;
  logic [31:0] i_s_axi_wdata = '0;
  logic [3:0] i_s_axi_wstrb = 4'hF;
  logic i_s_axi_awvalid = '0, i_s_axi_wvalid = '0, i_s_axi_bready = '0, i_s_axi_arvalid = '0, i_s_axi_rready = '0;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_irq;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, r;
  logic [31:0] o_s_axi_rdata, d;
  int n_fail = 0, tests_run = 0, cyc = 0;
  fpu_exception_state_frame dut (.*);
  always #20 i_core_clk = ~i_core_clk;
  ////////////////////////////////////////
  task automatic test_done;
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      n_fail++;
    end
  endtask
  // Ready flags are sampled mid-cycle, so the release lands on the edge that took them;
  // response readies stay high once raised; each call drives them high again, so they never drop between calls
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb_;
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= v;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    tb_ = 1'b0;
    while (!tb_)
    begin
      @(negedge i_core_clk);
      ta = o_s_axi_awready && i_s_axi_awvalid;
      tw = o_s_axi_wready && i_s_axi_wvalid;
      tb_ = o_s_axi_bvalid;
      r = o_s_axi_bresp;
      @(posedge i_core_clk);
      if (ta) i_s_axi_awvalid <= 1'b0;
      if (tw) i_s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, g;
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    g = 1'b0;
    while (!g)
    begin
      @(negedge i_core_clk);
      ta = o_s_axi_arready && i_s_axi_arvalid;
      g = o_s_axi_rvalid;
      d = o_s_axi_rdata;
      r = o_s_axi_rresp;
      @(posedge i_core_clk);
      if (ta) i_s_axi_arvalid <= 1'b0;
    end
  endtask
  // Operand of class k, tag code k: {single/double denormal, exponent, mantissa}
  function automatic logic [79:0] opnd(input int k);
    logic [63:0] m;
    m = {$urandom, $urandom};
    case (k)
      0: return {1'b0, 15'(($urandom % 32766) + 1), 1'b1, m[62:0]};
      1: return {1'b0, 15'h0, 64'h0};
      2: return {1'b0, 15'h7FFF, 64'h8000_0000_0000_0000};
      3: return {1'b0, 15'h7FFF, 1'b1, m[62:1], 1'b1};
      4: return {1'b0, 15'h0, 1'b0, m[62:1], 1'b1};
      default: return {1'b1, 15'h0, 1'b0, m[62:1], 1'b1};
    endcase
  endfunction
  ////////////////////////////////////////
  task automatic ev(input exc_case_t c, input logic irq_exp);
    logic [79:0] s, t;
    logic [66:0] im;
    logic [2:0] oc, st, dt;
    logic e3, post;
    logic [7:0] a;
    logic [31:0] x, mk;
    int k;
    k = (c == CASE_SNAN_OC3) ? 3 : $urandom % 6;
    dt = 3'($urandom % 6);
    s = opnd(k);
    t = opnd(int'(dt));
    im = 67'({$urandom, $urandom, $urandom});
    e3 = c inside {CASE_OVERFLOW_EXCEPTION_ARITH, CASE_UNDERFLOW_EXCEPTION_ARITH};
    post = c inside {CASE_SNAN_OC3, CASE_OPERAND_ERROR_OC3, CASE_OVERFLOW_EXCEPTION_MOVMEM, CASE_UNDERFLOW_EXCEPTION_MOVMEM};
    oc = post ? OPCLASS_OUT : (($urandom % 2) ? OPCLASS_MEM : OPCLASS_REG);
    st = (c inside {CASE_SNAN_OC3, CASE_OPERAND_ERROR_OC02, CASE_OPERAND_ERROR_OC3, CASE_DIV_ZERO}) ? 3'(k) : TAG_NORM;
    i_exc_case <= c;
    i_stage1_command_word <= {oc, 13'($urandom)};
    i_stage3_encoded_command <= 16'($urandom);
    {i_src_sd_denorm, i_src_exp, i_src_mant} <= s;
    {i_dst_sd_denorm, i_dst_exp, i_dst_mant} <= t;
    {i_src_sign, i_dst_sign, i_dst_present} <= {2'($urandom), 1'b1};
    i_int_mant <= im;
    {i_int_sign, i_int_exp, i_int_sticky, i_rnd_sign, i_rnd_exp} <= 33'({$urandom, $urandom});
    i_rnd_mant <= {$urandom, $urandom};
    i_round_int <= {$urandom, $urandom};
    i_exc_valid <= 1'b1;
    @(posedge i_core_clk);
    i_exc_valid <= 1'b0;
    @(negedge i_core_clk);
    chk("irq", {31'h0, irq_exp}, {31'h0, o_irq});
    @(posedge i_core_clk);
    // Stage three frames leave the stage one command word, hence the opclass, untouched
    mk = e3 ? 32'h001F_0007 : ((c == CASE_OPERAND_ERROR_OC02) ? 32'h00FF_0777 : 32'h00FF_0077);
    x = {8'h0, oc, 1'b0, c, 5'h0, dt, 1'b0, st, 1'b0, post, e3, !e3};
    rd(OFS_FLAGS);
    chk("flags", x & mk, d & mk);
    rd(OFS_CMD);
    chk("cmd", e3 ? {16'h0, i_stage3_encoded_command} : {16'h0, i_stage1_command_word},
      e3 ? {16'h0, d[31:16]} : {16'h0, d[15:0]});
    case (c)
      CASE_SNAN_OC3: {a, x} = {OFS_SRC_HI, s[63:32] | 32'h4000_0000};
      CASE_OPERAND_ERROR_OC02, CASE_DIV_ZERO: {a, x} = {OFS_DST_LO, t[31:0]};
      CASE_OPERAND_ERROR_OC3: {a, x} = {OFS_WB_LO, i_round_int[31:0]};
      CASE_OVERFLOW_EXCEPTION_MOVREG, CASE_OVERFLOW_EXCEPTION_MOVMEM: {a, x} = {OFS_DST_HI, i_rnd_mant[63:32]};
      CASE_UNDERFLOW_EXCEPTION_MOVREG, CASE_UNDERFLOW_EXCEPTION_MOVMEM: {a, x} = {OFS_DST_LO, im[33:2]};
      CASE_OVERFLOW_EXCEPTION_ARITH: {a, x} = {OFS_WB_SE, i_rnd_sign, 15'h0, 1'b0, i_rnd_exp};
      default: {a, x} = {OFS_WB_SE, i_int_sign, 15'h0, 1'b1, i_int_exp};
    endcase
    rd(a);
    chk("frame", x, d);
    if (c == CASE_UNDERFLOW_EXCEPTION_ARITH)
    begin
      rd(OFS_WB_TOP);
      chk("wb_top", {i_int_sticky, 28'h0, im[66:64]}, d);
      rd(OFS_WB_LO);
      chk("wb_lo", im[31:0], d);
    end
    wr(OFS_STATUS, 32'h7);
    chk("irq_clr", 32'h0, {31'h0, o_irq});
  endtask
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h8CC85918));
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    rd(OFS_CTRL);
    chk("ctrl_rst", 32'h1, d);
    rd(OFS_MASK);
    chk("mask_rst", 32'h0, d);
    rd(8'h3C);
    chk("rd_bad", 32'h2, {30'h0, r});
    wr(8'h42, 32'hFFFF_FFFF);
    chk("wr_bad", 32'h2, {30'h0, r});
    wr(OFS_MASK, 32'h1);
    for (int i = 0; i < 30; i++)
      ev(exc_case_t'(i % 10), 1'b1);
    // Back-to-back frames with a wrong opclass set built, mismatch and overrun
    i_exc_case <= CASE_SNAN_OC3;
    i_stage1_command_word <= 16'h0;
    i_exc_valid <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_exc_valid <= 1'b0;
    rd(OFS_STATUS);
    chk("status", 32'h7, d);
    wr(OFS_STATUS, 32'h7);
    // Capture disabled: the same event leaves status clear
    wr(OFS_CTRL, 32'h0);
    i_exc_valid <= 1'b1;
    @(posedge i_core_clk);
    i_exc_valid <= 1'b0;
    rd(OFS_STATUS);
    chk("status_off", 32'h0, d);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_MASK, 32'h0);
    ev(CASE_UNDERFLOW_EXCEPTION_ARITH, 1'b0);
    test_done();
  end
endmodule // tb
`default_nettype wire
